// [hdl/mfsc_stats.v]
`timescale 1ns/1ps
`include "mfsc_defs.vh"

module mfsc_stats
(
	input wire ref_clk,
	input wire arst_n,
	input wire counters_global_enable,
	input wire [3:0] counter_mask_reg,
	input wire rx_frame_done,
	input wire rx_too_long,
	input wire rx_fcs_error,
	input wire rx_length_error,
	input wire rx_align_error,
	input wire rx_overrun,
	input wire tx_frame_ok,
	input wire tx_frame_deferred,
	input wire tx_collided,
	input wire tx_excess_defer,
	input wire tx_frame_end,
	input wire reg_sel,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_wdata,
	output reg [31:0] reg_rdata,
	output reg reg_rd_valid,
	output reg counter_threshold_flag
);

	wire [31:0] rx_good_frame_count;
	wire [31:0] tx_good_frame_count;
	wire [31:0] tx_deferred_frame_count;
	wire [15:0] tx_excess_defer_count;
	wire hit_rx_good;
	wire hit_tx_good;
	wire hit_tx_deferred;
	wire hit_tx_excess;
	wire wr_rx_good;
	wire wr_tx_good;
	wire wr_tx_deferred;
	wire wr_tx_excess;
	wire rx_clean;
	wire inc_rx_good;
	wire inc_tx_good;
	wire inc_tx_deferred;
	wire inc_tx_excess;
	reg excess_seen;
	reg [31:0] next_rdata;

	// a counter runs only with the global enable set and its own mask bit clear
	function count_allowed;
		input global_en;
		input mask_bit;
		begin
			count_allowed = global_en & ~mask_bit;
		end
	endfunction

	// window offset decode, qualified by the window select
	function offset_hit;
		input sel;
		input [7:0] addr;
		input [7:0] offset;
		begin
			offset_hit = sel & (addr == offset);
		end
	endfunction

	// write strobes per counter
	assign wr_rx_good = reg_wr & offset_hit(reg_sel, reg_addr, `MFSC_OFS_RX_GOOD);
	assign wr_tx_good = reg_wr & offset_hit(reg_sel, reg_addr, `MFSC_OFS_TX_GOOD);
	assign wr_tx_deferred = reg_wr & offset_hit(reg_sel, reg_addr, `MFSC_OFS_TX_DEFERRED);
	assign wr_tx_excess = reg_wr & offset_hit(reg_sel, reg_addr, `MFSC_OFS_TX_EXCESS);

	// a received frame counts only when no fault came with it
	assign rx_clean = ~(rx_too_long | rx_fcs_error | rx_length_error
		| rx_align_error | rx_overrun); // [R2]
	assign inc_rx_good = rx_frame_done & rx_clean
		& count_allowed(counters_global_enable, counter_mask_reg[`MFSC_MASK_RX_GOOD]); // [R1] [R5]

	// successful transmissions
	assign inc_tx_good = tx_frame_ok
		& count_allowed(counters_global_enable, counter_mask_reg[`MFSC_MASK_TX_GOOD]); // [R15] [R18]

	// deferred first attempt, but never a frame that collided
	assign inc_tx_deferred = tx_frame_deferred & ~tx_collided
		& count_allowed(counters_global_enable, counter_mask_reg[`MFSC_MASK_TX_DEFERRED]); // [R6] [R7] [R10]

	// excessive deferral: first report of the frame only
	assign inc_tx_excess = tx_excess_defer & ~excess_seen
		& count_allowed(counters_global_enable, counter_mask_reg[`MFSC_MASK_TX_EXCESS]); // [R11] [R14]

	// per-frame guard; the mac may repeat the excess report while it keeps waiting,
	// so the guard is held until the frame ends
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			excess_seen <= 1'b0;
		else if (tx_frame_end)
			excess_seen <= 1'b0;
		else if (tx_excess_defer)
			excess_seen <= 1'b1; // [R11]
	end

	// received-ok counter
	mfsc_counter #(
		.WIDTH(`MFSC_WIDE),
		.RESET_VALUE(`MFSC_RST_WIDE),
		.THRESHOLD(`MFSC_THR_WIDE)
	) u_rx_good (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.load(wr_rx_good), // [R19]
		.load_value(reg_wdata),
		.inc(inc_rx_good), // [R3] [R4]
		.count(rx_good_frame_count),
		.hit(hit_rx_good)
	);

	// transmitted-ok counter
	mfsc_counter #(
		.WIDTH(`MFSC_WIDE),
		.RESET_VALUE(`MFSC_RST_WIDE),
		.THRESHOLD(`MFSC_THR_WIDE)
	) u_tx_good (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.load(wr_tx_good), // [R19]
		.load_value(reg_wdata),
		.inc(inc_tx_good), // [R16] [R17]
		.count(tx_good_frame_count),
		.hit(hit_tx_good)
	);

	// deferred-transmit counter
	mfsc_counter #(
		.WIDTH(`MFSC_WIDE),
		.RESET_VALUE(`MFSC_RST_WIDE),
		.THRESHOLD(`MFSC_THR_WIDE)
	) u_tx_deferred (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.load(wr_tx_deferred), // [R19]
		.load_value(reg_wdata),
		.inc(inc_tx_deferred), // [R8] [R9]
		.count(tx_deferred_frame_count),
		.hit(hit_tx_deferred)
	);

	// excessive-deferral counter, word wide; upper write data is ignored
	mfsc_counter #(
		.WIDTH(`MFSC_NARROW),
		.RESET_VALUE(`MFSC_RST_NARROW),
		.THRESHOLD(`MFSC_THR_NARROW)
	) u_tx_excess (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.load(wr_tx_excess), // [R19]
		.load_value(reg_wdata[15:0]),
		.inc(inc_tx_excess), // [R12] [R13]
		.count(tx_excess_defer_count),
		.hit(hit_tx_excess)
	);

	// any counter crossing its threshold pulses the shared update-statistics flag
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			counter_threshold_flag <= 1'b0;
		else
			counter_threshold_flag <= hit_rx_good | hit_tx_good
				| hit_tx_deferred | hit_tx_excess; // [R4] [R9] [R13] [R17]
	end

	// read mux; unmapped offsets read zero, narrow counter zero-extended
	always @*
	begin
		next_rdata = 32'h00000000;
		case (reg_addr)
			`MFSC_OFS_RX_GOOD: next_rdata = rx_good_frame_count;
			`MFSC_OFS_TX_GOOD: next_rdata = tx_good_frame_count;
			`MFSC_OFS_TX_DEFERRED: next_rdata = tx_deferred_frame_count;
			`MFSC_OFS_TX_EXCESS: next_rdata = {16'h0000, tx_excess_defer_count};
			default: next_rdata = 32'h00000000;
		endcase
	end

	// registered read answer, one cycle after the request
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reg_rdata <= 32'h00000000;
			reg_rd_valid <= 1'b0;
		end
		else
		begin
			reg_rd_valid <= reg_rd & reg_sel;
			if (reg_rd & reg_sel)
				reg_rdata <= next_rdata;
		end
	end

endmodule

// [hdl/mfsc_defs.vh]
// What this block does
// [R1] received-ok counter adds one for each frame received successfully
// [R2] received frames with length, FCS, alignment or overrun faults are not counted
// [R3] 32-bit received-ok counter wraps to zero after all-ones
// [R4] received-ok counter reaching 0xC0000000 raises the update-statistics flag
// [R5] received-ok counts only with global enable one and its mask bit zero
// [R6] deferred-transmit counter adds one per frame whose first attempt waited
// [R7] deferred frames that saw any collision are not counted
// [R8] 32-bit deferred-transmit counter wraps to zero after all-ones
// [R9] deferred-transmit counter reaching 0xC0000000 raises the update-statistics flag
// [R10] deferred-transmit counts only with global enable one and mask bit zero
// [R11] excessive-deferral counter adds at most one per frame past the defer limit
// [R12] 16-bit excessive-deferral counter wraps to zero after all-ones
// [R13] excessive-deferral counter reaching 0xC000 raises the update-statistics flag
// [R14] excessive-deferral counts only with global enable one and mask bit zero
// [R15] transmitted-ok counter adds one per frame sent successfully
// [R16] 32-bit transmitted-ok counter wraps to zero after all-ones
// [R17] transmitted-ok counter reaching 0xC0000000 raises the update-statistics flag
// [R18] transmitted-ok counts only with global enable one and mask bit zero
// [R19] software write loads a counter; write beats a coincident event
`ifndef MFSC_DEFS_VH
`define MFSC_DEFS_VH

// register offsets inside the io / memory window
`define MFSC_OFS_RX_GOOD 8'hB4
`define MFSC_OFS_TX_GOOD 8'hDC
`define MFSC_OFS_TX_DEFERRED 8'hE4
`define MFSC_OFS_TX_EXCESS 8'hFE

// counter widths
`define MFSC_WIDE 32
`define MFSC_NARROW 16

// reset values
`define MFSC_RST_WIDE 32'h00000000
`define MFSC_RST_NARROW 16'h0000

// threshold values that raise the update-statistics flag
`define MFSC_THR_WIDE 32'hC0000000
`define MFSC_THR_NARROW 16'hC000

// bit positions in the mask vector
`define MFSC_MASK_RX_GOOD 0
`define MFSC_MASK_TX_GOOD 1
`define MFSC_MASK_TX_DEFERRED 2
`define MFSC_MASK_TX_EXCESS 3

`endif

// [hdl/mfsc_counter.v]
`timescale 1ns/1ps
`include "mfsc_defs.vh"

module mfsc_counter #(
	parameter WIDTH = 32,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}},
	parameter [WIDTH-1:0] THRESHOLD = {WIDTH{1'b1}}
)
(
	input wire ref_clk,
	input wire arst_n,
	input wire load,
	input wire [WIDTH-1:0] load_value,
	input wire inc,
	output reg [WIDTH-1:0] count,
	output reg hit
);

	wire [WIDTH-1:0] next_count;

	// natural modulo arithmetic: all-ones plus one is zero
	assign next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};

	// load has priority; a dropped event is preferred over a torn load value
	always @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count <= RESET_VALUE;
			hit <= 1'b0;
		end
		else if (load)
		begin
			count <= load_value;
			hit <= 1'b0;
		end
		else if (inc)
		begin
			count <= next_count;
			hit <= (next_count == THRESHOLD);
		end
		else
		begin
			hit <= 1'b0;
		end
	end

endmodule

// [bench/mfsc_sva.sv]
`timescale 1ns/1ps
module mfsc_sva (
	input wire ref_clk,
	input wire arst_n,
	input wire counters_global_enable,
	input wire rx_frame_done,
	input wire tx_frame_ok,
	input wire tx_frame_deferred,
	input wire tx_excess_defer,
	input wire reg_sel,
	input wire reg_wr,
	input wire reg_rd,
	input wire reg_rd_valid,
	input wire counter_threshold_flag,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire [31:0] reg_rdata
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// flag must trace back to an event two edges earlier
	wire any_ev = rx_frame_done | tx_frame_ok | tx_frame_deferred | tx_excess_defer;
	wire mapped = reg_addr == 8'hB4 || reg_addr == 8'hDC || reg_addr == 8'hE4 || reg_addr == 8'hFE;
	sequence rd_req;
		reg_sel && reg_rd;
	endsequence
	sequence wr_rx;
		reg_sel && reg_wr && reg_addr == 8'hB4;
	endsequence
	// the quiet cycle keeps events and other writes from moving the value
	sequence quiet_rd_rx;
		!rx_frame_done && !reg_wr ##1 reg_sel && reg_rd && reg_addr == 8'hB4;
	endsequence
	chk_rd_answer: assert property (rd_req |=> reg_rd_valid)
		else $error("read not answered next cycle");
	chk_rd_cause: assert property (reg_rd_valid |-> $past(reg_sel && reg_rd))
		else $error("read valid without a read");
	chk_rdata_hold: assert property (!(reg_sel && reg_rd) |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	chk_unmapped_zero: assert property (rd_req and !mapped |=> reg_rdata == 32'h00000000)
		else $error("unmapped read not zero");
	chk_narrow_upper: assert property (rd_req and reg_addr == 8'hFE |=> reg_rdata[31:16] == 16'h0000)
		else $error("narrow counter upper half not zero");
	chk_write_load: assert property (wr_rx ##1 quiet_rd_rx |=> reg_rdata == $past(reg_wdata, 3))
		else $error("written value not read back");
	chk_flag_cause: assert property (counter_threshold_flag |-> $past(any_ev, 2))
		else $error("threshold flag without an event");
	chk_flag_off: assert property ($past(!counters_global_enable, 2) |-> !counter_threshold_flag)
		else $error("threshold flag while disabled");
endmodule
bind mfsc_stats mfsc_sva mfsc_sva_i (.*);

// [bench/mfsc_mac_model.sv]
`timescale 1ns/1ps
// stand-in for the mac event logic; each event is a one-cycle pulse set off the sampling edge
module mfsc_mac_model (
	input wire ref_clk,
	output wire rx_frame_done,
	output wire rx_too_long,
	output wire rx_fcs_error,
	output wire rx_length_error,
	output wire rx_align_error,
	output wire rx_overrun,
	output wire tx_frame_ok,
	output wire tx_frame_deferred,
	output wire tx_collided,
	output wire tx_excess_defer,
	output wire tx_frame_end
);
	reg [10:0] ev = 11'h000;
	assign {tx_frame_end, tx_excess_defer, tx_collided, tx_frame_deferred, tx_frame_ok, rx_overrun,
		rx_align_error, rx_length_error, rx_fcs_error, rx_too_long, rx_frame_done} = ev;
	// bit k of v raises the k-th event line, lowest first
	task send(input [10:0] v);
		@(negedge ref_clk);
		ev = v;
		@(negedge ref_clk);
		ev = 11'h000;
	endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic counters_global_enable = 1'b1;
	logic [3:0] counter_mask_reg = 4'h0;
	logic reg_sel = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000, top, thr;
	wire rx_frame_done, rx_too_long, rx_fcs_error, rx_length_error, rx_align_error, rx_overrun;
	wire tx_frame_ok, tx_frame_deferred, tx_collided, tx_excess_defer, tx_frame_end;
	wire [31:0] reg_rdata;
	wire reg_rd_valid, counter_threshold_flag;
	logic [7:0] adr [4] = '{8'hB4, 8'hDC, 8'hE4, 8'hFE};
	logic [10:0] evb [4] = '{11'h001, 11'h040, 11'h080, 11'h200};
	int errors = 0, n_compared = 0, cyc = 0;
	mfsc_stats mfsc_stats_i (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.counters_global_enable(counters_global_enable),
		.counter_mask_reg(counter_mask_reg),
		.rx_frame_done(rx_frame_done),
		.rx_too_long(rx_too_long),
		.rx_fcs_error(rx_fcs_error),
		.rx_length_error(rx_length_error),
		.rx_align_error(rx_align_error),
		.rx_overrun(rx_overrun),
		.tx_frame_ok(tx_frame_ok),
		.tx_frame_deferred(tx_frame_deferred),
		.tx_collided(tx_collided),
		.tx_excess_defer(tx_excess_defer),
		.tx_frame_end(tx_frame_end),
		.reg_sel(reg_sel),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid),
		.counter_threshold_flag(counter_threshold_flag)
	);
	mfsc_mac_model mfsc_mac_model_i (
		.ref_clk(ref_clk),
		.rx_frame_done(rx_frame_done),
		.rx_too_long(rx_too_long),
		.rx_fcs_error(rx_fcs_error),
		.rx_length_error(rx_length_error),
		.rx_align_error(rx_align_error),
		.rx_overrun(rx_overrun),
		.tx_frame_ok(tx_frame_ok),
		.tx_frame_deferred(tx_frame_deferred),
		.tx_collided(tx_collided),
		.tx_excess_defer(tx_excess_defer),
		.tx_frame_end(tx_frame_end)
	);
	// clock, and a ceiling far above the roughly 160 cycles the run needs
	initial forever #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			errors++;
			give_verdict();
		end
	end
	task chk(input [31:0] seen, input [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(negedge ref_clk);
		{reg_sel, reg_wr, reg_addr, reg_wdata} = {2'b11, a, d};
		@(negedge ref_clk);
		{reg_sel, reg_wr} = 2'b00;
	endtask
	task rd(input [7:0] a, input [31:0] e);
		@(negedge ref_clk);
		{reg_sel, reg_rd, reg_addr} = {2'b11, a};
		@(negedge ref_clk);
		{reg_sel, reg_rd} = 2'b00;
		chk(reg_rdata, e);
	endtask
	// one event, flag looked at in its single cycle, then frame end rearms the excess guard
	task fire(input int i, input f);
		mfsc_mac_model_i.send(evb[i]);
		@(negedge ref_clk);
		chk({31'h0, counter_threshold_flag}, {31'h0, f});
		mfsc_mac_model_i.send(11'h400);
	endtask
	task give_verdict;
		$display("errors=%0d n_compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(negedge ref_clk);
		arst_n = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			top = (i == 3) ? 32'h0000FFFF : 32'hFFFFFFFF;
			thr = (i == 3) ? 32'h0000C000 : 32'hC0000000;
			rd(adr[i], 32'h00000000);
			wr(adr[i], thr - 1);
			fire(i, 1'b1);
			rd(adr[i], thr);
			wr(adr[i], top);
			fire(i, 1'b0);
			rd(adr[i], 32'h00000000);
			counter_mask_reg = 4'h1 << i;
			fire(i, 1'b0);
			rd(adr[i], 32'h00000000);
			counter_mask_reg = 4'h0;
		end
		counters_global_enable = 1'b0;
		// frame end rides along so the excess guard is rearmed for the later test
		mfsc_mac_model_i.send(11'h6C1);
		for (int i = 0; i < 4; i++)
			rd(adr[i], 32'h00000000);
		counters_global_enable = 1'b1;
		for (int k = 1; k < 6; k++)
			mfsc_mac_model_i.send(11'h001 | (11'h001 << k));
		rd(8'hB4, 32'h00000000);
		mfsc_mac_model_i.send(11'h180);
		rd(8'hE4, 32'h00000000);
		mfsc_mac_model_i.send(11'h200);
		mfsc_mac_model_i.send(11'h200);
		rd(8'hFE, 32'h00000001);
		fork
			mfsc_mac_model_i.send(11'h001);
			wr(8'hB4, 32'h0000000A);
		join
		rd(8'hB4, 32'h0000000A);
		wr(8'hB0, 32'h00001234);
		rd(8'hB0, 32'h00000000);
		give_verdict();
	end
endmodule
